// ### verilog/ecc_log_pkg.sv
// types and constants shared by the dram ecc error logger.
// assumes an 8-byte ecc quadword and a byte-wide config read port.
package ecc_log_pkg;

  // chunk geometry: 32-byte chunk of 8-byte quadwords
  localparam int CHUNK_BYTES = 32;
  localparam int QWORD_BYTES = 8;
  localparam int QW_PER_CHUNK = CHUNK_BYTES / QWORD_BYTES;
  localparam int SYN_W = 8;
  localparam int SRC_W = 6;
  localparam int ADDR_LSB = 7;
  localparam int ADDR_MSB = 31;

  // config-space byte offsets
  localparam logic [7:0] OFF_ADDR_LOG0 = 8'h58;
  localparam logic [7:0] OFF_ADDR_LOG1 = 8'h59;
  localparam logic [7:0] OFF_ADDR_LOG2 = 8'h5a;
  localparam logic [7:0] OFF_ADDR_LOG3 = 8'h5b;
  localparam logic [7:0] OFF_SYNDROME = 8'h5c;
  localparam logic [7:0] OFF_REQUESTER = 8'h5d;

  // reset values
  localparam logic [SYN_W-1:0] SYN_RESET = 8'h00;
  localparam logic [SRC_W-1:0] SRC_RESET = 6'h00;

  // source code bases
  localparam logic [SRC_W-1:0] SRC_CPU = 6'h00;
  localparam logic [SRC_W-1:0] SRC_VC0_BASE = 6'h08;
  localparam logic [SRC_W-1:0] SRC_VC1_BASE = 6'h0a;
  localparam logic [SRC_W-1:0] SRC_PCIE1_BASE = 6'h10;
  localparam logic [SRC_W-1:0] SRC_PCIE2_BASE = 6'h20;
  localparam logic [SRC_W-1:0] SRC_PCIE_STEP2 = 6'h02;
  localparam logic [SRC_W-1:0] SRC_PCIE_STEP3 = 6'h04;
  localparam logic [SRC_W-1:0] SRC_PCIE_STEP4 = 6'h05;

  // requester classes from the tagging logic
  typedef enum logic [2:0] {
    REQ_CPU,
    REQ_LINK_VC0,
    REQ_LINK_VC1,
    REQ_PCIE_PRI,
    REQ_PCIE_SEC
  } req_class_t;

  // lock state of the captured fields
  typedef enum logic [1:0] {
    LOG_EMPTY,
    LOG_SINGLE,
    LOG_MULTI
  } log_state_t;

  // one checked read chunk from the ecc checker
  typedef struct packed {
    logic valid;
    logic [QW_PER_CHUNK-1:0] sbe;
    logic [QW_PER_CHUNK-1:0] mbe;
    logic [QW_PER_CHUNK-1:0][SYN_W-1:0] syndrome;
    logic [ADDR_MSB:ADDR_LSB] lineAddr;
    logic channel;
    req_class_t reqClass;
    logic [1:0] reqSub;
  } ecc_chunk_t;

  // captured log contents
  typedef struct packed {
    logic [SYN_W-1:0] syndrome;
    logic [SRC_W-1:0] sourceCode;
    logic [ADDR_MSB:ADDR_LSB] lineAddr;
    logic channel;
  } ecc_log_t;

endpackage

// ### verilog/ecc_source_encoder.sv
// maps a requester class and sub-index onto the 6-bit error source code.
// assumes the tagging logic gives a class plus a small sub-index.
`timescale 1ns/100ps
module ecc_source_encoder #(
  parameter bit HAS_SECONDARY = 1'b1
) (
  input ecc_log_pkg::req_class_t reqClass,
  input logic [1:0] reqSub,
  output logic [ecc_log_pkg::SRC_W-1:0] sourceCode
);
  import ecc_log_pkg::*;

  logic [SRC_W-1:0] pcieStep;

  // the four legal pcie offsets; no reserved code is reachable
  always_comb begin
    case (reqSub)
      2'd0: pcieStep = '0;
      2'd1: pcieStep = SRC_PCIE_STEP2;
      2'd2: pcieStep = SRC_PCIE_STEP3;
      default: pcieStep = SRC_PCIE_STEP4;
    endcase
  end

  // out-of-range sub-indices: vc1 sub 3 clamps to its base code, vc0 uses only the low sub-index bit
  always_comb begin
    case (reqClass)
      REQ_CPU: sourceCode = SRC_CPU;
      REQ_LINK_VC0: sourceCode = SRC_VC0_BASE | {5'b0, reqSub[0]};
      REQ_LINK_VC1: sourceCode = (reqSub == 2'd3) ? SRC_VC1_BASE
                                 : SRC_VC1_BASE + {4'b0, reqSub};
      REQ_PCIE_PRI: sourceCode = SRC_PCIE1_BASE + pcieStep;
      REQ_PCIE_SEC: sourceCode = HAS_SECONDARY ? SRC_PCIE2_BASE + pcieStep
                                 : SRC_PCIE1_BASE + pcieStep;
      default: sourceCode = SRC_CPU;
    endcase
  end
endmodule // ecc_source_encoder

// ### verilog/dram_ecc_error_logger.sv
// dram ecc error logger: captures syndrome, source, address and channel
// of the first ecc error after software clears the error flag, or of a
// later multi-bit error that replaces a single-bit record.
// assumes the ecc checker presents a whole 32-byte chunk in one cycle and
// the status logic pulses flagClear when software clears the error flag.
// the lock state and captured fields are sticky: nrst never clears them, powerGoodRstN clears both, and flagClear empties the lock state.
`timescale 1ns/100ps

module dram_ecc_error_logger #(
  parameter int QW_COUNT = ecc_log_pkg::QW_PER_CHUNK,
  parameter bit HAS_SECONDARY = 1'b1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic powerGoodRstN,
  input ecc_log_pkg::ecc_chunk_t chunkIn,
  input wire logic flagClear,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  output logic [7:0] cfgRdData,
  output ecc_log_pkg::ecc_log_t logOut,
  output logic logMulti
);
  import ecc_log_pkg::*;

  // the one-hot priority and the byte layout are built for four quadwords
  if (QW_COUNT != QW_PER_CHUNK) begin : g_bad_qw
    $error("QW_COUNT must match the 32-byte chunk");
  end

  // lock state, captured log and read-back byte
  log_state_t state_q, state_d;
  ecc_log_t log_q, log_d;
  logic [7:0] rdData_q, rdData_d;
  logic [QW_COUNT-1:0] anyErr;
  logic [QW_COUNT-1:0] firstErr;
  logic [QW_COUNT-1:0] firstMbe;
  logic [SYN_W-1:0] firstErrSyn;
  logic [SYN_W-1:0] firstMbeSyn;
  logic [SRC_W-1:0] srcCode;
  logic chunkErr;
  logic chunkMbe;
  logic effEmpty;
  logic effSingle;
  logic captureFirst;
  logic captureOverride;
  logic capture;
  // capture-path picks
  logic [SYN_W-1:0] captureSyn;
  log_state_t lockNext;
  // config read decode
  logic hitAddr0;
  logic hitAddr1;
  logic hitAddr2;
  logic hitAddr3;
  logic hitSyn;
  logic hitSrc;
  logic [7:0] addrByte0;

  // per-quadword one-hot of first failing and first multi-bit quadword;
  // index 0 is the first quadword of the chunk, so the lowest set bit wins
  for (genvar i = 0; i < QW_COUNT; i++) begin : g_qw
    assign anyErr[i] = chunkIn.sbe[i] | chunkIn.mbe[i];
    if (i == 0) begin : g_lo
      assign firstErr[i] = anyErr[i];
      assign firstMbe[i] = chunkIn.mbe[i];
    end else begin : g_hi
      assign firstErr[i] = anyErr[i] & ~|anyErr[i-1:0];
      assign firstMbe[i] = chunkIn.mbe[i] & ~|chunkIn.mbe[i-1:0];
    end
  end

  // one-hot select of the wanted syndromes; the priority is already in the
  // one-hot, so the or-tree needs no further ordering
  always_comb begin
    firstErrSyn = '0;
    firstMbeSyn = '0;
    for (int i = 0; i < QW_COUNT; i++) begin
      firstErrSyn = firstErrSyn | ({SYN_W{firstErr[i]}} & chunkIn.syndrome[i]);
      firstMbeSyn = firstMbeSyn | ({SYN_W{firstMbe[i]}} & chunkIn.syndrome[i]);
    end
  end

  // source code from the tag of the same chunk, so it always matches the syndrome
  ecc_source_encoder #(
    .HAS_SECONDARY(HAS_SECONDARY)
  ) u_src (
    .reqClass(chunkIn.reqClass),
    .reqSub(chunkIn.reqSub),
    .sourceCode(srcCode)
  );

  // capture decision; a clear in the same cycle as an error lets it in, so an
  // error that races the software clear is never lost (set wins over clear);
  // a multi-bit record refuses everything until the clear reopens it
  assign chunkErr = chunkIn.valid & (|anyErr);
  assign chunkMbe = chunkIn.valid & (|chunkIn.mbe);
  assign effEmpty = flagClear | (state_q == LOG_EMPTY);
  assign effSingle = ~flagClear & (state_q == LOG_SINGLE);
  assign captureFirst = effEmpty & chunkErr;
  assign captureOverride = effSingle & chunkMbe;
  assign capture = captureFirst | captureOverride;

  // syndrome and lock level for the capturing chunk; a mixed first chunk
  // locks as multi-bit yet reports its first failing quadword
  assign captureSyn = captureFirst ? firstErrSyn : firstMbeSyn;
  assign lockNext = chunkMbe ? LOG_MULTI : LOG_SINGLE;

  // all captured fields load together so they describe one error; the
  // address and channel follow the same lock rules as the syndrome
  always_comb begin
    log_d = log_q;
    if (capture) begin
      log_d.syndrome = captureSyn;
      log_d.sourceCode = srcCode;
      log_d.lineAddr = chunkIn.lineAddr;
      log_d.channel = chunkIn.channel;
    end
  end

  // lock state per record kind; multi-bit in the capturing chunk wins for locking,
  // and only a single-bit record may be upgraded by a later multi-bit chunk
  always_comb begin
    case (state_q)
      LOG_EMPTY: begin
        if (capture) begin
          state_d = lockNext;
        end else begin
          state_d = LOG_EMPTY;
        end
      end
      LOG_SINGLE: begin
        if (capture) begin
          state_d = lockNext;
        end else if (flagClear) begin
          state_d = LOG_EMPTY;
        end else begin
          state_d = LOG_SINGLE;
        end
      end
      LOG_MULTI: begin
        if (capture) begin
          state_d = lockNext;
        end else if (flagClear) begin
          state_d = LOG_EMPTY;
        end else begin
          state_d = LOG_MULTI;
        end
      end
      default: begin
        state_d = LOG_EMPTY;
      end
    endcase
  end

  // sticky lock state: of the two resets only power-good reset clears it, not the ordinary reset,
  // so a record survives a warm reset and software can still read it afterwards
  always_ff @(posedge mclk or negedge powerGoodRstN) begin
    if (!powerGoodRstN) begin
      state_q <= LOG_EMPTY;
    end else begin
      state_q <= state_d;
    end
  end

  // sticky captured fields, on the same power-good reset as the lock state
  always_ff @(posedge mclk or negedge powerGoodRstN) begin
    if (!powerGoodRstN) begin
      log_q <= '{syndrome: SYN_RESET, sourceCode: SRC_RESET, lineAddr: '0, channel: 1'b0};
    end else begin
      log_q <= log_d;
    end
  end

  // config byte decode as one hit line per mapped offset; an unmapped offset
  // hits nothing, so the and-or select below gives zero with no default term
  assign hitAddr0 = (cfgAddr == OFF_ADDR_LOG0);
  assign hitAddr1 = (cfgAddr == OFF_ADDR_LOG1);
  assign hitAddr2 = (cfgAddr == OFF_ADDR_LOG2);
  assign hitAddr3 = (cfgAddr == OFF_ADDR_LOG3);
  assign hitSyn = (cfgAddr == OFF_SYNDROME);
  assign hitSrc = (cfgAddr == OFF_REQUESTER);
  assign addrByte0 = {log_q.lineAddr[ADDR_LSB], 6'b0, log_q.channel};

  // and-or select of the addressed byte; the hit lines are mutually exclusive
  assign rdData_d = ({8{hitAddr0}} & addrByte0)
                  | ({8{hitAddr1}} & log_q.lineAddr[15:8])
                  | ({8{hitAddr2}} & log_q.lineAddr[23:16])
                  | ({8{hitAddr3}} & log_q.lineAddr[31:24])
                  | ({8{hitSyn}} & log_q.syndrome)
                  | ({8{hitSrc}} & {2'b00, log_q.sourceCode});

  // read data registered; holds between reads, and the ordinary reset may
  // clear it because it is only a copy, never the sticky log itself
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= 8'h00;
    end else if (cfgRdEn) begin
      rdData_q <= rdData_d;
    end
  end

  // outputs straight from the registers; logMulti is a decode of the lock state
  assign cfgRdData = rdData_q;
  assign logOut = log_q;
  assign logMulti = (state_q == LOG_MULTI);
endmodule // dram_ecc_error_logger

// ### verification/ecc_checker_model.sv
// behavioural ecc checker: presents one checked read chunk per call.
// assumes the caller steps it once per cycle just after the clock edge.
`timescale 1ns/100ps
module ecc_checker_model (
  output ecc_log_pkg::ecc_chunk_t chunkOut
);
  import ecc_log_pkg::*;
  // idle cycles show the inverse of the last chunk, so stale data never looks real
  initial chunkOut = '0;
  task automatic put(input ecc_chunk_t c);
    chunkOut = c.valid ? c : {1'b0, ~chunkOut[$bits(ecc_chunk_t)-2:0]};
  endtask
endmodule // ecc_checker_model

// ### verification/dram_ecc_logger_asserts.sv
// checker for the dram ecc error logger, watching its ports only.
// assumes power-good reset guards the log and nrst guards the read port.
`timescale 1ns/100ps
module dram_ecc_logger_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic powerGoodRstN,
  input ecc_log_pkg::ecc_chunk_t chunkIn,
  input wire logic flagClear,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgRdData,
  input ecc_log_pkg::ecc_log_t logOut,
  input wire logic logMulti
);
  import ecc_log_pkg::*;
  wire hit = chunkIn.valid && |(chunkIn.sbe | chunkIn.mbe);
  wire hitM = chunkIn.valid && |chunkIn.mbe;
  default clocking @(posedge mclk); endclocking
  default disable iff (!powerGoodRstN);
  // lock and hold rules, legal source codes
  mbe_lock_a: assert property (hitM |=> logMulti) else $error("multi error not locked");
  multi_hold_a: assert property (logMulti && !flagClear |=> logMulti && $stable(logOut))
    else $error("multi record moved");
  clear_unlock_a: assert property (flagClear && !hitM |=> !logMulti)
    else $error("clear left lock");
  idle_hold_a: assert property (!hit |=> $stable(logOut)) else $error("log moved w/o error");
  single_stay_a: assert property (!logMulti && !hitM |=> !logMulti)
    else $error("lock without multi error");
  src_legal_a: assert property (logOut.sourceCode inside {6'h00, 6'h08, 6'h09, 6'h0a, 6'h0b,
    6'h0c, 6'h10, 6'h12, 6'h14, 6'h15, 6'h20, 6'h22, 6'h24, 6'h25}) else $error("reserved code");
  // read port
  syn_read_a: assert property (disable iff (!nrst || !powerGoodRstN)
    cfgRdEn && cfgAddr == OFF_SYNDROME && !chunkIn.valid |=> cfgRdData == logOut.syndrome)
    else $error("syndrome read wrong");
  src_read_a: assert property (disable iff (!nrst || !powerGoodRstN)
    cfgRdEn && cfgAddr == OFF_REQUESTER && !chunkIn.valid |=> cfgRdData == {2'h0, logOut.sourceCode})
    else $error("source read wrong");
  unmapped_read_a: assert property (disable iff (!nrst)
    cfgRdEn && (cfgAddr < OFF_ADDR_LOG0 || cfgAddr > OFF_REQUESTER) |=> cfgRdData == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (disable iff (!nrst) !cfgRdEn |=> $stable(cfgRdData))
    else $error("read data moved");
endmodule // dram_ecc_logger_asserts

bind dram_ecc_error_logger dram_ecc_logger_asserts u_asserts (.mclk(mclk), .nrst(nrst),
  .powerGoodRstN(powerGoodRstN), .chunkIn(chunkIn), .flagClear(flagClear), .cfgRdEn(cfgRdEn),
  .cfgAddr(cfgAddr), .cfgRdData(cfgRdData), .logOut(logOut), .logMulti(logMulti));

// ### verification/test_dram_ecc_error_logger.sv
// testbench for the dram ecc error logger: random chunks, clears and reads.
// assumes the checker model drives chunkIn and the asserts are bound in.
`timescale 1ns/100ps
module test_dram_ecc_error_logger;
  import ecc_log_pkg::*;
  logic mclk, nrst, powerGoodRstN, flagClear, cfgRdEn, logMulti;
  logic [7:0] cfgAddr, cfgRdData, eCfg;
  logic [1:0] st;
  logic [31:0] r;
  ecc_chunk_t chunkIn, c;
  ecc_log_t logOut, e;
  logic [48:0] notes[$];
  int err_total, tests_run;
  ecc_checker_model u_ecc (.chunkOut(chunkIn));
  dram_ecc_error_logger u_dut (.mclk(mclk), .nrst(nrst), .powerGoodRstN(powerGoodRstN),
    .chunkIn(chunkIn), .flagClear(flagClear), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgRdData(cfgRdData), .logOut(logOut), .logMulti(logMulti));
  task automatic check(input logic [48:0] seen, input logic [48:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [5:0] code(req_class_t k, logic [1:0] s);
    case (k)
      REQ_CPU: return 6'h00;
      REQ_LINK_VC0: return {5'h04, s[0]};
      REQ_LINK_VC1: return (s == 2'h3) ? 6'h0a : 6'h0a + 6'(s);
      REQ_PCIE_PRI: return (s > 2'h1) ? 6'h12 + 6'(s) : 6'h10 + 6'({s, 1'b0});
      default: return (s > 2'h1) ? 6'h22 + 6'(s) : 6'h20 + 6'({s, 1'b0});
    endcase
  endfunction
  function automatic logic [7:0] first(ecc_chunk_t k, logic [3:0] m);
    first = 8'h00;
    for (int i = 3; i >= 0; i--) if (m[i]) first = k.syndrome[i];
  endfunction
  function automatic logic [7:0] reg_val(logic [7:0] a);
    case (a)
      OFF_ADDR_LOG0: return {e.lineAddr[7], 6'h00, e.channel};
      OFF_ADDR_LOG1: return e.lineAddr[15:8];
      OFF_ADDR_LOG2: return e.lineAddr[23:16];
      OFF_ADDR_LOG3: return e.lineAddr[31:24];
      OFF_SYNDROME: return e.syndrome;
      OFF_REQUESTER: return {2'h0, e.sourceCode};
      default: return 8'h00;
    endcase
  endfunction
  // one cycle of stimulus; reads never share a cycle with an error bit, though a valid chunk may come with them
  task automatic op(input bit rd, input bit clr, input logic [3:0] sb, input logic [3:0] mb,
      input req_class_t k, input logic [1:0] s, input logic [7:0] a);
    logic [1:0] eff;
    if (rd) begin
      sb = 4'h0;
      mb = 4'h0;
    end
    c = ecc_chunk_t'(72'({$urandom, $urandom, $urandom}));
    c.valid = c.valid | (|(sb | mb));
    c.sbe = sb;
    c.mbe = mb;
    c.reqClass = k;
    c.reqSub = s;
    u_ecc.put(c);
    flagClear = clr;
    cfgRdEn = rd;
    cfgAddr = a;
    eff = clr ? 2'd0 : st;
    if (rd) eCfg = reg_val(a);
    // a valid chunk with no error bit set captures nothing
    if ((sb | mb) != 4'h0 && (eff == 2'd0 || (eff == 2'd1 && mb != 4'h0))) begin
      e = '{first(c, (eff == 2'd0) ? (sb | mb) : mb), code(k, s), c.lineAddr, c.channel};
      st = (mb != 4'h0) ? 2'd2 : 2'd1;
    end else st = eff;
    @(posedge mclk);
    #1;
    notes.push_back({eCfg, st == 2'd2, e});
  endtask
  // scoreboard side: results settle one edge after the request
  always @(negedge mclk) if (notes.size() > 0) check({cfgRdData, logMulti, logOut}, notes.pop_front());
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard, far beyond the roughly 500 cycles the tests need
  initial begin
    #100us;
    err_total++;
    finish_test();
  end
  initial begin
    {nrst, powerGoodRstN, flagClear, cfgRdEn, cfgAddr, st, e, eCfg} = '0;
    void'($urandom(38));
    repeat (16) @(posedge mclk);
    #1;
    {nrst, powerGoodRstN} = 2'b11;
    for (int k = 0; k < 5; k++) for (int s = 0; s < 4; s++) begin
      op(1'b0, 1'b1, 4'h6, 4'h0, req_class_t'(k), 2'(s), 8'h00);
      op(1'b1, 1'b0, 4'h0, 4'h0, REQ_CPU, 2'h0, OFF_REQUESTER);
    end
    repeat (400) begin
      r = $urandom;
      op(r[0] & r[1], r[4:2] == 3'h0, r[5] ? r[11:8] : 4'h0, (r[7:6] == 2'h0) ? r[15:12] : 4'h0,
        req_class_t'(r[18:16] % 3'd5), r[20:19], 8'h56 + 8'(r[24:21] % 4'd10));
    end
    // quiet cycle, then one more edge so the last note is checked before a reset lands
    op(1'b0, 1'b0, 4'h0, 4'h0, REQ_CPU, 2'h0, 8'h00);
    @(posedge mclk);
    #1;
    nrst = 1'b0;
    eCfg = 8'h00;
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    op(1'b1, 1'b0, 4'h0, 4'h0, REQ_CPU, 2'h0, OFF_SYNDROME);
    @(posedge mclk);
    #1;
    powerGoodRstN = 1'b0;
    {e, st} = '0;
    @(posedge mclk);
    #1;
    powerGoodRstN = 1'b1;
    op(1'b1, 1'b0, 4'h0, 4'h0, REQ_CPU, 2'h0, OFF_SYNDROME);
    repeat (2) @(posedge mclk);
    finish_test();
  end
endmodule // test_dram_ecc_error_logger
